/* mtr_router.sv */
// top of the multifunction terminal router
// assumes single ahb-lite master, pads resolved outside, 50 MHz hclk
`timescale 1ns/1ns
module mtr_router (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               global_reset_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic               eeprom_load,
  input  wire logic [31:0]        eeprom_data,
  input  wire mtr_pkg::mtr_func_t func_in,
  input  wire logic [6:0]         pad_i,
  output mtr_pkg::mtr_pad_t       pad,
  output logic                    smartcard_debug_receive,
  output logic                    event_output
);
  import mtr_pkg::*;

  // ***************************************************************
  // bus address phase capture
  // ***************************************************************
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] terminal_function_select;
  logic [GEN_N-1:0] gen_sts;
  logic [GEN_N-1:0] gen_en;
  logic [GEN_N-1:0] gen_out;
  logic [GEN_N-1:0] gen_in;
  logic [PIN_N-1:0] is_gen_in;
  logic [PIN_N-1:0] pin_gen_out;
  logic [PIN_N-1:0] s1;
  logic [PIN_N-1:0] s2;
  logic [PIN_N-1:0] s3;
  logic [GEN_N-1:0] gen_chg;
  logic [GEN_N-1:0] gen_active;
  logic             sts_clr_wr;
  logic [2:0]       sync_fill;

  // only 32-bit writes land; reads answer with zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite && (hsize == 3'b010);
      wr_addr <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // read data is captured in the address phase, so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:0] == REG_ROUTE_OFF) begin
        hrdata <= terminal_function_select & ROUTE_MASK;
      end else if (haddr[7:0] == REG_GEN_OFF) begin
        hrdata <= {3'b000, gen_out, 3'b000, gen_in, 3'b000, gen_en, 3'b000, gen_sts};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ***************************************************************
  // routing register
  // ***************************************************************
  // only the global reset loads ROUTE_RESET into it; bus reset leaves the routing alone
  always_ff @(posedge hclk or negedge global_reset_n) begin
    if (!global_reset_n) begin
      terminal_function_select <= ROUTE_RESET;
    end else if (eeprom_load) begin
      terminal_function_select <= eeprom_data & ROUTE_MASK;
    end else if (wr_pend && wr_addr == REG_ROUTE_OFF) begin
      terminal_function_select <= hwdata & ROUTE_MASK;
    end
  end

  // ***************************************************************
  // general-purpose event block
  // ***************************************************************
  always_ff @(posedge hclk or negedge global_reset_n) begin
    if (!global_reset_n) begin
      gen_en  <= 5'h00;
      gen_out <= 5'h00;
    end else if (wr_pend && wr_addr == REG_GEN_OFF) begin
      gen_en  <= hwdata[GEN_EN_LSB +: GEN_N];
      gen_out <= hwdata[GEN_OUT_LSB +: GEN_N];
    end
  end

  // three-stage pad sync; first stage read only by the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 7'h00;
      s2 <= 7'h00;
      s3 <= 7'h00;
      sync_fill <= 3'h0;
    end else begin
      s1 <= pad_i;
      s2 <= s1;
      s3 <= s2;
      sync_fill <= {sync_fill[1:0], 1'b1};
    end
  end

  // inputs 0..4 sit on terminals 0,1,2,4,5
  assign gen_in     = {s3[5], s3[4], s3[2], s3[1], s3[0]};
  assign gen_active = {is_gen_in[5], is_gen_in[4], is_gen_in[2], is_gen_in[1], is_gen_in[0]};
  // no change counts until all three stages hold pad samples, else a bus
  // reset with a pin held high would fake an input event
  assign gen_chg    = {GEN_N{sync_fill[2]}} & gen_active
                      & ({s3[5], s3[4], s3[2], s3[1], s3[0]}
                      ^ {s2[5], s2[4], s2[2], s2[1], s2[0]});
  assign sts_clr_wr = wr_pend && wr_addr == REG_GEN_OFF;

  // write-one-to-clear, a fresh change wins over the clear
  always_ff @(posedge hclk or negedge global_reset_n) begin
    if (!global_reset_n) begin
      gen_sts <= 5'h00;
    end else begin
      gen_sts <= (gen_sts & ~(sts_clr_wr ? hwdata[GEN_STS_LSB +: GEN_N] : 5'h00))
                 | gen_chg;
    end
  end

  assign event_output = ~|(gen_sts & gen_en);
  assign pin_gen_out  = {1'b0, gen_out[4], gen_out[3], 1'b0, gen_out[2], 2'b00};

  // ***************************************************************
  // per-terminal routing
  // ***************************************************************
  for (genvar i = 0; i < PIN_N; i++) begin : g_pin
    mtr_pin_route #(.PIN(i)) u_route (
      .sel       (terminal_function_select[SEL_W*i +: SEL_W]),
      .fn        (func_in),
      .gen_out   (pin_gen_out[i]),
      .event_out (event_output),
      .pad_o     (pad.o[i]),
      .pad_oe    (pad.oe[i]),
      .is_gen_in (is_gen_in[i])
    );
  end

  // debug receive comes in on terminal 5 when selected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smartcard_debug_receive <= 1'b0;
    end else begin
      smartcard_debug_receive <= (terminal_function_select[23:20] == SEL_DBG_RX) & s3[5];
    end
  end

endmodule

/* mtr_pkg.sv */
// package for the multifunction terminal router
// assumes one 50 MHz clock and an ahb-lite register port
package mtr_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0]  REG_ROUTE_OFF  = 8'h8c;
  localparam logic [7:0]  REG_GEN_OFF    = 8'h88;
  localparam logic [31:0] ROUTE_RESET    = 32'h0000_1000;
  localparam logic [31:0] ROUTE_MASK     = 32'h0fff_ffff;
  localparam int          SEL_W          = 4;
  localparam int          PIN_N          = 7;
  localparam int          GEN_N          = 5;
  localparam int          GEN_STS_LSB    = 0;
  localparam int          GEN_EN_LSB     = 8;
  localparam int          GEN_IN_LSB     = 16;
  localparam int          GEN_OUT_LSB    = 24;

  // ***************************************************************
  // selector codes
  // ***************************************************************
  localparam logic [3:0] SEL_GEN_IN    = 4'h0;
  localparam logic [3:0] SEL_GEN_OUT   = 4'h1;
  localparam logic [3:0] SEL_LOCK      = 4'h2;
  localparam logic [3:0] SEL_IRQ3      = 4'h3;
  localparam logic [3:0] SEL_IRQ4      = 4'h4;
  localparam logic [3:0] SEL_IRQ5      = 4'h5;
  localparam logic [3:0] SEL_DBG_TX    = 4'h5;
  localparam logic [3:0] SEL_DBG_RX    = 4'h4;
  localparam logic [3:0] SEL_PWM       = 4'h8;
  localparam logic [3:0] SEL_IRQ9      = 4'h9;
  localparam logic [3:0] SEL_IRQ10     = 4'ha;
  localparam logic [3:0] SEL_IRQ11     = 4'hb;
  localparam logic [3:0] SEL_INTC      = 4'hb;
  localparam logic [3:0] SEL_HC_LED    = 4'hb;
  localparam logic [3:0] SEL_INTD      = 4'ha;
  localparam logic [3:0] SEL_LED_A     = 4'hc;
  localparam logic [3:0] SEL_RING      = 4'hc;
  localparam logic [3:0] SEL_SOCKET_LED   = 4'hd;
  localparam logic [3:0] SEL_TMUX      = 4'hd;
  localparam logic [3:0] SEL_EVENT     = 4'he;
  localparam logic [3:0] SEL_IRQ15     = 4'hf;
  localparam logic [3:0] SEL_IRQ7      = 4'hf;
  localparam logic [3:0] SEL_CLKRUN    = 4'h1;
  localparam logic [3:0] SEL_SERIRQ    = 4'h1;
  localparam logic [3:0] SEL_IRQ2      = 4'h2;

  // internal functions offered to the terminals
  typedef struct packed {
    logic [15:0] irq;
    logic        clkrun;
    logic        serial_interrupt;
    logic        pci_lock;
    logic        intc;
    logic        intd;
    logic        card_audio_pwm;
    logic        smartcard_debug_transmit;
    logic        socket_a_led;
    logic        socket_led;
    logic        host_controller_led;
    logic        ring_output;
    logic        test_multiplexer;
  } mtr_func_t;

  // per-terminal pad signals
  typedef struct packed {
    logic [PIN_N-1:0] o;
    logic [PIN_N-1:0] oe;
  } mtr_pad_t;

endpackage

/* mtr_pin_route.sv */
// one terminal's selector decode
// assumes function inputs are on the same clock
`timescale 1ns/1ns
module mtr_pin_route #(
  parameter int PIN = 0
) (
  input  wire logic [3:0]        sel,
  input  wire mtr_pkg::mtr_func_t fn,
  input  wire logic              gen_out,
  input  wire logic              event_out,
  output logic                   pad_o,
  output logic                   pad_oe,
  output logic                   is_gen_in
);
  import mtr_pkg::*;

  // ***************************************************************
  // decode
  // ***************************************************************
  always_comb begin
    pad_o     = 1'b0;
    pad_oe    = 1'b0;
    is_gen_in = 1'b0;
    if (PIN == 6 || PIN == 3) begin
      if (sel == SEL_CLKRUN) begin
        pad_o  = (PIN == 6) ? fn.clkrun : fn.serial_interrupt;
        pad_oe = 1'b1;
      end else if (sel != 4'h0) begin
        pad_o  = fn.irq[sel];
        pad_oe = 1'b1;
      end
    end else begin
      pad_oe = 1'b1;
      unique case (sel)
        SEL_GEN_IN: begin
          pad_oe    = 1'b0;
          is_gen_in = 1'b1;
        end
        SEL_GEN_OUT: begin
          if (PIN == 0 || PIN == 1) begin
            pad_oe = 1'b0;
          end else begin
            pad_o = gen_out;
          end
        end
        SEL_LOCK: begin
          if (PIN == 4) pad_o = fn.pci_lock;
          else pad_oe = 1'b0;
        end
        SEL_IRQ3: begin
          if (PIN >= 2) pad_o = fn.irq[3];
          else pad_oe = 1'b0;
        end
        SEL_IRQ4: begin
          if (PIN == 2 || PIN == 4) pad_o = fn.irq[4];
          else if (PIN == 5) pad_oe = 1'b0; // debug receive is an input
          else pad_oe = 1'b0;
        end
        SEL_IRQ5: begin
          if (PIN == 2 || PIN == 5) pad_o = fn.irq[5];
          else if (PIN == 4) pad_o = fn.smartcard_debug_transmit;
          else pad_oe = 1'b0;
        end
        SEL_PWM: begin
          pad_o = fn.card_audio_pwm;
          if (PIN == 1) pad_oe = 1'b0;
        end
        SEL_IRQ9: begin
          if (PIN == 0 || PIN == 4 || PIN == 5) pad_o = fn.irq[9];
          else pad_oe = 1'b0;
        end
        SEL_IRQ10: begin
          if (PIN == 0 || PIN == 2) pad_o = fn.irq[10];
          else if (PIN == 4) pad_o = fn.intd;
          else pad_oe = 1'b0;
        end
        SEL_IRQ11: begin
          if (PIN == 0) pad_o = fn.irq[11];
          else if (PIN == 2) pad_o = fn.intc;
          else if (PIN == 5) pad_o = fn.host_controller_led;
          else pad_oe = 1'b0;
        end
        SEL_LED_A: begin
          if (PIN == 2 || PIN == 4) pad_o = fn.ring_output;
          else pad_o = fn.socket_a_led;
        end
        SEL_SOCKET_LED: begin
          if (PIN == 4 || PIN == 5) pad_o = fn.socket_led;
          else if (PIN == 2) pad_o = fn.test_multiplexer;
          else pad_oe = 1'b0;
        end
        SEL_EVENT: pad_o = event_out;
        SEL_IRQ15: pad_o = (PIN == 2) ? fn.irq[7] : fn.irq[15];
        default: pad_oe = 1'b0;
      endcase
    end
  end

endmodule

/* mtr_router_properties.sv */
// assertions on the terminal router ports
// assumes one master, word transfers, hready fed from hreadyout
`timescale 1ns/1ns
module mtr_router_properties (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               global_reset_n,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [2:0]         hsize,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  input wire logic               eeprom_load,
  input wire logic [31:0]        eeprom_data,
  input wire mtr_pkg::mtr_func_t func_in,
  input wire mtr_pkg::mtr_pad_t  pad
);
  import mtr_pkg::*;
  // ****************
  // routing shadow
  // ****************
  logic        hit;
  logic        wr_ph;
  logic        rd_ph;
  logic [31:0] rt;
  assign hit = hsel && htrans[1] && hready && haddr[7:0] == REG_ROUTE_OFF;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
    end else begin
      wr_ph <= hit && hwrite && hsize == 3'h2;
      rd_ph <= hit && !hwrite;
    end
  end
  // preload beats a bus write in the same cycle, as the design does
  always_ff @(posedge hclk or negedge global_reset_n) begin
    if (!global_reset_n) rt <= ROUTE_RESET;
    else if (eeprom_load) rt <= eeprom_data & ROUTE_MASK;
    else if (wr_ph) rt <= hwdata & ROUTE_MASK;
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !global_reset_n);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  a_rsvd_zero: assert property (rd_ph |-> hrdata[31:28] == 4'h0)
    else $error("reserved routing bits read nonzero");
  a_pin6_irq: assert property (rt[27:24] >= 4'h2 |->
    pad.oe[6] && pad.o[6] == func_in.irq[rt[27:24]]) else $error("pin 6 irq wrong");
  a_pin6_free: assert property (rt[27:24] == 4'h0 |-> !pad.oe[6])
    else $error("pin 6 driven on reserved code");
  a_pin3_ser: assert property (rt[15:12] == SEL_SERIRQ |->
    pad.oe[3] && pad.o[3] == func_in.serial_interrupt) else $error("pin 3 serial wrong");
  a_pin4_lock: assert property (rt[19:16] == SEL_LOCK |-> pad.o[4] == func_in.pci_lock)
    else $error("pin 4 lock wrong");
  a_pin0_pwm: assert property (rt[3:0] == SEL_PWM |->
    pad.oe[0] && pad.o[0] == func_in.card_audio_pwm) else $error("pin 0 pwm wrong");
  a_pin1_free: assert property (rt[7:4] == 4'hd |-> !pad.oe[1])
    else $error("pin 1 driven on reserved code");
endmodule
bind mtr_router mtr_router_properties chk_u (
  .hclk(hclk), .hresetn(hresetn), .global_reset_n(global_reset_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .eeprom_load(eeprom_load), .eeprom_data(eeprom_data), .func_in(func_in), .pad(pad)
);

/* mtr_board_model.sv */
// board side: internal function sources and resolved pad levels
// assumes the bench sets the undriven pad levels
`timescale 1ns/1ns
module mtr_board_model (
  input  wire logic              hclk,
  input  wire logic [6:0]        lvl,
  input  wire mtr_pkg::mtr_pad_t pad,
  output mtr_pkg::mtr_func_t     func_in,
  output logic [6:0]             pad_i
);
  import mtr_pkg::*;
  logic [27:0] cnt = 28'h0;
  // odd step so every function line keeps moving
  always @(posedge hclk) cnt <= cnt + 28'h2b5a3c7;
  assign func_in = mtr_func_t'(cnt);
  // a driven pad shows the router's level, else the board level
  assign pad_i = (pad.oe & pad.o) | (~pad.oe & lvl);
endmodule

/* tb.sv */
// self-checking bench for the terminal router
// assumes the board model feeds func_in and pad_i
`timescale 1ns/1ns
module tb;
  import mtr_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        global_reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        eeprom_load = 1'b0;
  logic [31:0] eeprom_data = 32'h0;
  logic [6:0]  lvl = 7'h0;
  logic [6:0]  pad_i;
  logic        event_output;
  logic        dbg_rx;
  logic [2:0]  sz = 3'h2;
  logic [31:0] rd;
  logic [15:0] row;
  logic [27:0] fv;
  mtr_func_t   func_in;
  mtr_pad_t    pad;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          pin;
  // rows: pin, code, function bit (ff means pad not driven)
  logic [15:0] rows [42] = '{16'h60ff, 16'h610b, 16'h620e, 16'h6f1b, 16'h30ff, 16'h310a,
    16'h3713, 16'h54ff, 16'h5b02, 16'h5d03, 16'h52ff, 16'h4209, 16'h4505, 16'h4a07,
    16'h4c01, 16'h46ff, 16'h2b08, 16'h2d00, 16'h2f13, 16'h29ff, 16'h1c04, 16'h1f1b,
    16'h1dff, 16'h0806, 16'h0a16, 16'h0dff, 16'h5511, 16'h5c04, 16'h5806, 16'h430f,
    16'h4410, 16'h4d03, 16'h4f1b, 16'h2410, 16'h2a16, 16'h2c01, 16'h22ff, 16'h11ff,
    16'h18ff, 16'h0915, 16'h0b17, 16'h01ff};
  always #10 hclk = ~hclk;
  assign fv = func_in;
  mtr_router dut_u (.hclk(hclk), .hresetn(hresetn), .global_reset_n(global_reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .eeprom_load(eeprom_load), .eeprom_data(eeprom_data),
    .func_in(func_in), .pad_i(pad_i), .pad(pad), .smartcard_debug_receive(dbg_rx),
    .event_output(event_output));
  mtr_board_model brd_u (.hclk(hclk), .lvl(lvl), .pad(pad), .func_in(func_in),
    .pad_i(pad_i));
  // ****************
  // tasks
  // ****************
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      final_report();
    end
  end
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    global_reset_n <= 1'b1;
    rd_chk(32'h8c, 32'h0000_1000);
    for (int i = 0; i < $size(rows); i++) begin
      row = rows[i];
      pin = row[15:12];
      xfer(1'b1, 32'h8c, {28'h0, row[11:8]} << (4 * pin));
      rd_chk(32'h8c, {28'h0, row[11:8]} << (4 * pin));
      #5;
      chk(pad.oe[pin], row[7:0] != 8'hff);
      if (row[7:0] != 8'hff)
        chk(pad.o[pin], fv[row[4:0]]);
      // a second sample a cycle later, so a wrong line seldom matches by luck
      @(posedge hclk);
      #5;
      if (row[7:0] != 8'hff)
        chk(pad.o[pin], fv[row[4:0]]);
    end
    xfer(1'b1, 32'h8c, 32'hffff_ffff);
    rd_chk(32'h8c, 32'h0fff_ffff);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(32'h8c, 32'h0fff_ffff);
    sz <= 3'h1;
    xfer(1'b1, 32'h8c, 32'h0);
    sz <= 3'h2;
    rd_chk(32'h8c, 32'h0fff_ffff);
    rd_chk(32'h90, 32'h0);
    eeprom_data <= 32'hf234_5678;
    eeprom_load <= 1'b1;
    @(posedge hclk);
    eeprom_load <= 1'b0;
    rd_chk(32'h8c, 32'h0234_5678);
    global_reset_n <= 1'b0;
    repeat (2) @(posedge hclk);
    global_reset_n <= 1'b1;
    rd_chk(32'h8c, 32'h0000_1000);
    xfer(1'b1, 32'h88, 32'h0000_041f);
    lvl[2] <= 1'b1;
    for (int k = 0; k < 12 && event_output !== 1'b0; k++)
      @(posedge hclk);
    chk(event_output, 1'b0);
    rd_chk(32'h88, 32'h0004_0404);
    xfer(1'b1, 32'h8c, 32'h0000_00e0);
    #5;
    chk({pad.oe[1], pad.o[1]}, 2'h2);
    xfer(1'b1, 32'h88, 32'h0400_0404);
    // settle on one routing pass, as software is meant to
    xfer(1'b1, 32'h8c, 32'h0000_1100);
    #5;
    chk(event_output, 1'b1);
    chk({pad.oe[2], pad.o[2]}, 2'h3);
    xfer(1'b1, 32'h8c, 32'h0040_0000);
    lvl[5] <= 1'b1;
    repeat (5) @(posedge hclk);
    #5;
    chk({pad.oe[5], dbg_rx}, 2'h1);
    xfer(1'b1, 32'h8c, 32'h0000_1000);
    @(posedge hclk);
    #5;
    chk(dbg_rx, 1'b0);
    // a bus-only reset must not fake input changes on pins held high
    xfer(1'b1, 32'h88, 32'h0000_001f);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    rd_chk(32'h88, 32'h0014_0000);
    final_report();
  end
endmodule
